// ### rtl/pmicid_pkg.sv
// constants and types of the identification register bank
package pmicid_pkg;
    // register map
    localparam logic [7:0] ADDR_MAKER    = 8'h00;
    localparam logic [7:0] ADDR_LOT      = 8'h01;
    localparam logic [7:0] ADDR_DATE     = 8'h02;
    localparam logic [7:0] ADDR_KEY      = 8'h03;
    localparam logic [7:0] VOL_MEM_FIRST = 8'h04;
    localparam logic [7:0] VOL_LAST      = 8'h1b;
    localparam logic [7:0] NVM_FIRST     = 8'h40;
    localparam logic [7:0] NVM_LAST      = 8'h71;
    localparam int         VOL_CNT       = int'(VOL_LAST - VOL_MEM_FIRST) + 1;
    localparam int         NVM_CNT       = int'(NVM_LAST - NVM_FIRST) + 1;
    localparam logic [7:0] PTR_STEP      = 8'h01;
    localparam logic [7:0] READ_ZERO     = 8'h00;
    // write key
    localparam logic [7:0] KEY_VALUE     = 8'ha5;
    localparam logic [7:0] KEY_CLEARED   = 8'h00;
    // nonvolatile source locations of the copied identification bytes
    localparam logic [7:0] NVM_SRC_LOT   = 8'hb1;
    localparam logic [7:0] NVM_SRC_DATE  = 8'hb2;
    // serial port
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h68;
    localparam logic [3:0] BIT_ZERO      = 4'h0;
    localparam logic [3:0] BIT_STEP      = 4'h1;
    localparam logic [3:0] BIT_LAST      = 4'h7;
    localparam logic [3:0] BYTE_BITS     = 4'h8;
    // identification defaults, values arbitrary
    localparam logic [1:0] MAKER_DEFAULT = 2'h3;
    localparam logic [5:0] REV_DEFAULT   = 6'h05;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DEV,
        ST_DEV_ACK,
        ST_PTR,
        ST_PTR_ACK,
        ST_WR,
        ST_WR_ACK,
        ST_RD,
        ST_RD_ACK
    } pmicid_state_t;

    typedef enum logic [2:0] {
        LD_LOT,
        LD_LOT_WAIT,
        LD_DATE,
        LD_DATE_WAIT,
        LD_DONE
    } pmicid_load_t;
endpackage : pmicid_pkg

// ### rtl/pmicid_regs.sv
// serial target port and register bank with identification registers
//
// Notes on behaviour
// RULE1 - map: volatile 0x00..0x1B, nonvolatile 0x40..0x71, the rest reads zero.
// RULE2 - volatile registers reached over serial port; lockout makes reads zero.
// RULE3 - offset 0x00 bits 7:6 return fixed two-bit maker code.
// RULE4 - offset 0x00 bits 5:0 return six-bit setting revision number.
// RULE5 - offset 0x01 returns lot number copied from nonvolatile location 0xB1.
// RULE6 - offset 0x02 returns date code copied from nonvolatile location 0xB2.
// RULE7 - each write needs key A5 at 0x03 first; any write clears key. A write to 0x03 loads the key instead of clearing it.
// RULE8 - multi-byte transfers step register pointer by one per byte.
// RULE9 - writes to 0x00..0x02 ignored; reads there have no side effects.
`timescale 1ns/10ps
module pmicid_regs #(
    parameter logic [6:0] DEV_ADDR   = pmicid_pkg::DEV_ADDR_DEFAULT,
    parameter logic [1:0] MAKER_CODE = pmicid_pkg::MAKER_DEFAULT,
    parameter logic [5:0] SETTING_REV = pmicid_pkg::REV_DEFAULT
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda,
    output logic            o_sda_oe,
    input  wire logic       i_input_undervoltage_lockout,
    output logic            o_nvm_rd,
    output logic [7:0]      o_nvm_addr,
    input  wire logic       i_nvm_ack,
    input  wire logic [7:0] i_nvm_data
);
    typedef struct packed {
        pmicid_pkg::pmicid_state_t            state;
        pmicid_pkg::pmicid_load_t             ld;
        logic [3:0]                           bitcnt;
        logic [7:0]                           shreg;
        logic [7:0]                           ptr;
        logic                                 rw;
        logic                                 mack;
        logic                                 sda_oe;
        logic                                 nvm_rd;
        logic [7:0]                           nvm_addr;
        logic [7:0]                           key;
        logic [7:0]                           lot;
        logic [7:0]                           date;
        logic                                 scl_p;
        logic                                 sda_p;
        logic [pmicid_pkg::VOL_CNT-1:0][7:0]  vol;
        logic [pmicid_pkg::NVM_CNT-1:0][7:0]  nvm;
    } pmicid_s_t;

    pmicid_s_t  s_q;
    pmicid_s_t  s_d;
    logic       scl_l;
    logic       sda_l;
    logic       lock_l;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       wr_fire;
    logic [7:0] rd_val;
    logic [7:0] vidx;
    logic [7:0] nidx;
    logic [7:0] widx_v;
    logic [7:0] widx_n;

    pmicid_sync #(.RESET_LEVEL(1'b1)) u_sync_scl (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_async   (i_scl),
        .o_level   (scl_l)
    );
    pmicid_sync #(.RESET_LEVEL(1'b1)) u_sync_sda (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_async   (i_sda),
        .o_level   (sda_l)
    );
    pmicid_sync #(.RESET_LEVEL(1'b0)) u_sync_lock (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_async   (i_input_undervoltage_lockout),
        .o_level   (lock_l)
    );

    assign scl_rise = scl_l & ~s_q.scl_p;
    assign scl_fall = ~scl_l & s_q.scl_p;
    assign start_c  = scl_l & s_q.scl_p & s_q.sda_p & ~sda_l;
    assign stop_c   = scl_l & s_q.scl_p & ~s_q.sda_p & sda_l;
    assign wr_fire  = (s_q.state == pmicid_pkg::ST_WR) && scl_fall
                      && (s_q.bitcnt == pmicid_pkg::BYTE_BITS);
    assign vidx     = s_q.ptr - pmicid_pkg::VOL_MEM_FIRST;
    assign nidx     = s_q.ptr - pmicid_pkg::NVM_FIRST;
    assign widx_v   = vidx;
    assign widx_n   = nidx;

    // read mux, side-effect free
    always_comb begin
        rd_val = pmicid_pkg::READ_ZERO;
        // RULE2 lockout reads zero
        if (lock_l) begin
            rd_val = pmicid_pkg::READ_ZERO;
        end else if (s_q.ptr == pmicid_pkg::ADDR_MAKER) begin
            // RULE3 RULE4 identification word
            rd_val = {MAKER_CODE, SETTING_REV};
        end else if (s_q.ptr == pmicid_pkg::ADDR_LOT) begin
            rd_val = s_q.lot;
        end else if (s_q.ptr == pmicid_pkg::ADDR_DATE) begin
            rd_val = s_q.date;
        end else if (s_q.ptr == pmicid_pkg::ADDR_KEY) begin
            rd_val = s_q.key;
        end else if (s_q.ptr <= pmicid_pkg::VOL_LAST) begin
            // RULE1 volatile section
            rd_val = s_q.vol[vidx];
        end else if (s_q.ptr >= pmicid_pkg::NVM_FIRST
                     && s_q.ptr <= pmicid_pkg::NVM_LAST) begin
            // RULE1 nonvolatile section
            rd_val = s_q.nvm[nidx];
        end
    end

    always_comb begin
        s_d       = s_q;
        s_d.scl_p = scl_l;
        s_d.sda_p = sda_l;
        s_d.nvm_rd = 1'b0;

        // copy of identification bytes after reset
        case (s_q.ld)
            pmicid_pkg::LD_LOT: begin
                s_d.nvm_rd   = 1'b1;
                s_d.nvm_addr = pmicid_pkg::NVM_SRC_LOT;
                s_d.ld       = pmicid_pkg::LD_LOT_WAIT;
            end
            pmicid_pkg::LD_LOT_WAIT: begin
                // RULE5 lot number copy
                if (i_nvm_ack) begin
                    s_d.lot = i_nvm_data;
                    s_d.ld  = pmicid_pkg::LD_DATE;
                end
            end
            pmicid_pkg::LD_DATE: begin
                s_d.nvm_rd   = 1'b1;
                s_d.nvm_addr = pmicid_pkg::NVM_SRC_DATE;
                s_d.ld       = pmicid_pkg::LD_DATE_WAIT;
            end
            pmicid_pkg::LD_DATE_WAIT: begin
                // RULE6 date code copy
                if (i_nvm_ack) begin
                    s_d.date = i_nvm_data;
                    s_d.ld   = pmicid_pkg::LD_DONE;
                end
            end
            pmicid_pkg::LD_DONE: begin
                s_d.ld = pmicid_pkg::LD_DONE;
            end
            default: begin
                s_d.ld = pmicid_pkg::LD_DONE;
            end
        endcase

        if (start_c) begin
            s_d.state  = pmicid_pkg::ST_DEV;
            s_d.bitcnt = pmicid_pkg::BIT_ZERO;
            s_d.sda_oe = 1'b0;
        end else if (stop_c) begin
            s_d.state  = pmicid_pkg::ST_IDLE;
            s_d.sda_oe = 1'b0;
        end else begin
            case (s_q.state)
                pmicid_pkg::ST_IDLE: begin
                    s_d.sda_oe = 1'b0;
                end
                pmicid_pkg::ST_DEV, pmicid_pkg::ST_PTR,
                pmicid_pkg::ST_WR: begin
                    if (scl_rise) begin
                        s_d.shreg  = {s_q.shreg[6:0], sda_l};
                        s_d.bitcnt = s_q.bitcnt + pmicid_pkg::BIT_STEP;
                    end else if (scl_fall
                                 && s_q.bitcnt == pmicid_pkg::BYTE_BITS) begin
                        s_d.sda_oe = 1'b1;
                        if (s_q.state == pmicid_pkg::ST_DEV) begin
                            s_d.rw    = s_q.shreg[0];
                            s_d.state = pmicid_pkg::ST_DEV_ACK;
                            if (s_q.shreg[7:1] != DEV_ADDR) begin
                                // not our address: stay off the line
                                s_d.sda_oe = 1'b0;
                                s_d.state  = pmicid_pkg::ST_IDLE;
                            end
                        end else if (s_q.state == pmicid_pkg::ST_PTR) begin
                            s_d.ptr   = s_q.shreg;
                            s_d.state = pmicid_pkg::ST_PTR_ACK;
                        end else begin
                            s_d.state = pmicid_pkg::ST_WR_ACK;
                            // RULE8 step after write byte
                            s_d.ptr   = s_q.ptr + pmicid_pkg::PTR_STEP;
                            if (s_q.ptr == pmicid_pkg::ADDR_KEY) begin
                                s_d.key = s_q.shreg;
                            end else begin
                                // RULE7 key consumed by any write to an offset other than 0x03
                                s_d.key = pmicid_pkg::KEY_CLEARED;
                                // RULE9 identification bytes never written
                                if (s_q.key == pmicid_pkg::KEY_VALUE
                                    && s_q.ptr >= pmicid_pkg::VOL_MEM_FIRST
                                    && s_q.ptr <= pmicid_pkg::VOL_LAST) begin
                                    s_d.vol[widx_v] = s_q.shreg;
                                end else if (s_q.key == pmicid_pkg::KEY_VALUE
                                    && s_q.ptr >= pmicid_pkg::NVM_FIRST
                                    && s_q.ptr <= pmicid_pkg::NVM_LAST) begin
                                    s_d.nvm[widx_n] = s_q.shreg;
                                end
                            end
                        end
                    end
                end
                pmicid_pkg::ST_DEV_ACK, pmicid_pkg::ST_PTR_ACK,
                pmicid_pkg::ST_WR_ACK: begin
                    if (scl_fall) begin
                        s_d.sda_oe = 1'b0;
                        s_d.bitcnt = pmicid_pkg::BIT_ZERO;
                        if (s_q.state == pmicid_pkg::ST_DEV_ACK && s_q.rw) begin
                            s_d.shreg  = rd_val;
                            s_d.ptr    = s_q.ptr + pmicid_pkg::PTR_STEP;
                            s_d.sda_oe = ~rd_val[7];
                            s_d.state  = pmicid_pkg::ST_RD;
                        end else if (s_q.state == pmicid_pkg::ST_DEV_ACK) begin
                            s_d.state = pmicid_pkg::ST_PTR;
                        end else begin
                            s_d.state = pmicid_pkg::ST_WR;
                        end
                    end
                end
                pmicid_pkg::ST_RD: begin
                    if (scl_fall) begin
                        s_d.bitcnt = s_q.bitcnt + pmicid_pkg::BIT_STEP;
                        if (s_q.bitcnt == pmicid_pkg::BIT_LAST) begin
                            s_d.sda_oe = 1'b0;
                            s_d.mack   = 1'b0;
                            s_d.state  = pmicid_pkg::ST_RD_ACK;
                        end else begin
                            s_d.shreg  = {s_q.shreg[6:0], 1'b0};
                            s_d.sda_oe = ~s_q.shreg[6];
                        end
                    end
                end
                pmicid_pkg::ST_RD_ACK: begin
                    if (scl_rise) begin
                        s_d.mack = ~sda_l;
                    end else if (scl_fall) begin
                        s_d.bitcnt = pmicid_pkg::BIT_ZERO;
                        if (s_q.mack) begin
                            // RULE8 next byte from next offset
                            s_d.shreg  = rd_val;
                            s_d.ptr    = s_q.ptr + pmicid_pkg::PTR_STEP;
                            s_d.sda_oe = ~rd_val[7];
                            s_d.state  = pmicid_pkg::ST_RD;
                        end else begin
                            // host refused more: wait for stop or start
                            s_d.state = pmicid_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    s_d.state  = pmicid_pkg::ST_IDLE;
                    s_d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s_q       <= '0;
            s_q.scl_p <= 1'b1;
            s_q.sda_p <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // open-drain data line only ever pulls low
    assign o_sda      = 1'b0;
    assign o_sda_oe   = s_q.sda_oe;
    assign o_nvm_rd   = s_q.nvm_rd;
    assign o_nvm_addr = s_q.nvm_addr;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    sequence s_wr_key;
        wr_fire && s_q.ptr == pmicid_pkg::ADDR_KEY;
    endsequence
    sequence s_wr_other;
        wr_fire && s_q.ptr != pmicid_pkg::ADDR_KEY;
    endsequence

    property p_key_clear;
        s_wr_other |=> s_q.key == pmicid_pkg::KEY_CLEARED;
    endproperty
    a_key_clear: assert property (p_key_clear) // RULE7
        else $error("key not cleared after write");

    property p_key_load;
        s_wr_key |=> s_q.key == $past(s_q.shreg);
    endproperty
    a_key_load: assert property (p_key_load) // RULE7
        else $error("key write not stored");

    property p_wr_locked;
        wr_fire && s_q.ptr != pmicid_pkg::ADDR_KEY
            && s_q.key != pmicid_pkg::KEY_VALUE
            |=> $stable(s_q.vol) && $stable(s_q.nvm);
    endproperty
    a_wr_locked: assert property (p_wr_locked) // RULE7
        else $error("write without key changed storage");

    property p_id_ro;
        wr_fire && s_q.ptr <= pmicid_pkg::ADDR_DATE
            && s_q.ld == pmicid_pkg::LD_DONE
            |=> $stable(s_q.lot) && $stable(s_q.date)
                && $stable(s_q.vol) && $stable(s_q.nvm);
    endproperty
    a_id_ro: assert property (p_id_ro) // RULE9
        else $error("identification byte changed by write");

    property p_maker;
        s_q.ptr == pmicid_pkg::ADDR_MAKER && !lock_l
            |-> rd_val[7:6] == MAKER_CODE;
    endproperty
    a_maker: assert property (p_maker) // RULE3
        else $error("maker code wrong");

    property p_rev;
        s_q.ptr == pmicid_pkg::ADDR_MAKER && !lock_l
            |-> rd_val[5:0] == SETTING_REV;
    endproperty
    a_rev: assert property (p_rev) // RULE4
        else $error("setting revision wrong");

    property p_lot_copy;
        s_q.ld == pmicid_pkg::LD_LOT_WAIT && i_nvm_ack
            |=> s_q.lot == $past(i_nvm_data)
                && s_q.ld == pmicid_pkg::LD_DATE;
    endproperty
    a_lot_copy: assert property (p_lot_copy) // RULE5
        else $error("lot number not copied");

    property p_date_copy;
        s_q.ld == pmicid_pkg::LD_DATE
            |=> o_nvm_rd && o_nvm_addr == pmicid_pkg::NVM_SRC_DATE;
    endproperty
    a_date_copy: assert property (p_date_copy) // RULE6
        else $error("date code fetch address wrong");

    property p_autoinc;
        s_q.state == pmicid_pkg::ST_RD_ACK && scl_fall && s_q.mack
            && !start_c && !stop_c
            |=> s_q.ptr == $past(s_q.ptr) + pmicid_pkg::PTR_STEP
                && s_q.state == pmicid_pkg::ST_RD;
    endproperty
    a_autoinc: assert property (p_autoinc) // RULE8
        else $error("read pointer did not step");

    property p_lock;
        lock_l |-> rd_val == pmicid_pkg::READ_ZERO;
    endproperty
    a_lock: assert property (p_lock) // RULE2
        else $error("read not zero during lockout");

    property p_gap;
        s_q.ptr > pmicid_pkg::VOL_LAST && s_q.ptr < pmicid_pkg::NVM_FIRST
            |-> rd_val == pmicid_pkg::READ_ZERO;
    endproperty
    a_gap: assert property (p_gap) // RULE1
        else $error("unmapped offset read not zero");
endmodule : pmicid_regs

// ### rtl/pmicid_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module pmicid_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_async,
    output logic      o_level
);
    typedef struct packed {
        logic f1;
        logic f2;
        logic f3;
        logic level;
    } pmicid_sync_s_t;

    pmicid_sync_s_t s_q;
    pmicid_sync_s_t s_d;

    always_comb begin
        s_d    = s_q;
        s_d.f1 = i_async;
        s_d.f2 = s_q.f1;
        s_d.f3 = s_q.f2;
        // only a level seen by both later stages counts
        if (s_q.f2 == s_q.f3) begin
            s_d.level = s_q.f3;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s_q <= '{RESET_LEVEL, RESET_LEVEL, RESET_LEVEL, RESET_LEVEL};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_level = s_q.level;
endmodule : pmicid_sync

// ### test/pmic_identification_registers_tb.sv
// self-checking bench of the identification register bank
`timescale 1ns/10ps
module pmic_identification_registers_tb;
    localparam logic [6:0] DEV = pmicid_pkg::DEV_ADDR_DEFAULT;
    localparam logic [7:0] ID0 = {pmicid_pkg::MAKER_DEFAULT,
                                  pmicid_pkg::REV_DEFAULT};
    logic        i_clk_sys;
    logic        i_rst;
    logic        scl;
    logic        host_oe;
    logic        o_sda;
    logic        o_sda_oe;
    logic        sda_wire;
    logic        lockout;
    logic        o_nvm_rd;
    logic [7:0]  o_nvm_addr;
    logic        nvm_ack;
    logic [7:0]  nvm_data;
    logic        rd_valid;
    logic [7:0]  rd_byte;
    logic [7:0]  exp_q[$];
    logic [31:0] seed;
    logic [7:0]  lot_v, date_v;
    logic [7:0]  wv[9];
    logic [7:0]  addr_t[9] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h1b,
                              8'h1c, 8'h40, 8'h71, 8'h72};
    logic        ok;
    int          fails, n_tests, nvm_n;

    // pull-up on the data line, anyone may pull it low
    assign sda_wire = ~(host_oe | (o_sda_oe & ~o_sda));

    pmicid_regs dut (
        .i_clk_sys                    (i_clk_sys),
        .i_rst                        (i_rst),
        .i_scl                        (scl),
        .i_sda                        (sda_wire),
        .o_sda                        (o_sda),
        .o_sda_oe                     (o_sda_oe),
        .i_input_undervoltage_lockout (lockout),
        .o_nvm_rd                     (o_nvm_rd),
        .o_nvm_addr                   (o_nvm_addr),
        .i_nvm_ack                    (nvm_ack),
        .i_nvm_data                   (nvm_data)
    );

    pmicid_host #(.DEV_ADDR(DEV)) host (
        .i_clk_sys  (i_clk_sys),
        .i_sda      (sda_wire),
        .o_scl      (scl),
        .o_sda_oe   (host_oe),
        .o_rd_valid (rd_valid),
        .o_rd_byte  (rd_byte)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    // slow storage: answers a few cycles late, data scrambled when idle
    always begin
        @(posedge i_clk_sys);
        #1;
        if (o_nvm_rd === 1'b1) begin
            check(o_nvm_addr, (nvm_n == 0) ? pmicid_pkg::NVM_SRC_LOT
                                           : pmicid_pkg::NVM_SRC_DATE);
            repeat (3) @(posedge i_clk_sys);
            #1;
            nvm_ack = 1'b1;
            nvm_data = (nvm_n == 0) ? lot_v : date_v;
            @(posedge i_clk_sys);
            #1;
            nvm_ack = 1'b0;
            nvm_data = ~nvm_data;
            nvm_n++;
        end
    end

    always @(posedge i_clk_sys) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("Error at %0t: seen %h expected none", $time,
                         rd_byte);
            end else
                check(rd_byte, exp_q.pop_front());
        end
    end

    initial begin
        repeat (90000) @(posedge i_clk_sys);
        fails++;
        print_verdict();
    end

    initial begin
        fails = 0;
        n_tests = 0;
        nvm_n = 0;
        i_rst = 1'b1;
        lockout = 1'b0;
        nvm_ack = 1'b0;
        nvm_data = 8'h00;
        seed = lfsr(32'h412f);
        lot_v = seed[7:0];
        seed = lfsr(seed);
        date_v = seed[15:8];
        repeat (5) @(posedge i_clk_sys);
        #1;
        i_rst = 1'b0;
        host.tick(40);
        exp_q.push_back(ID0);
        exp_q.push_back(lot_v);
        exp_q.push_back(date_v);
        exp_q.push_back(pmicid_pkg::KEY_CLEARED);
        host.rd(8'h00, 4);
        for (int i = 0; i < 9; i++) begin
            seed = lfsr(seed);
            host.wr(DEV, pmicid_pkg::ADDR_KEY, pmicid_pkg::KEY_VALUE, ok);
            host.wr(DEV, addr_t[i], seed[7:0], ok);
            check({7'h00, ok}, 8'h01);
            case (addr_t[i])
                8'h00: wv[i] = ID0;
                8'h01: wv[i] = lot_v;
                8'h02: wv[i] = date_v;
                8'h1c, 8'h72: wv[i] = 8'h00;
                default: wv[i] = seed[7:0];
            endcase
            exp_q.push_back(wv[i]);
            host.rd(addr_t[i], 1);
        end
        // wrong key, then a keyed write followed by an unkeyed one
        host.wr(DEV, pmicid_pkg::ADDR_KEY, 8'h5a, ok);
        host.wr(DEV, 8'h04, ~wv[3], ok);
        host.wr(DEV, pmicid_pkg::ADDR_KEY, pmicid_pkg::KEY_VALUE, ok);
        host.wr(DEV, 8'h71, ~wv[7], ok);
        host.wr(DEV, 8'h71, wv[7], ok);
        exp_q.push_back(wv[3]);
        host.rd(8'h04, 1);
        exp_q.push_back(~wv[7]);
        exp_q.push_back(pmicid_pkg::KEY_CLEARED);
        host.rd(8'h71, 1);
        host.rd(8'h03, 1);
        exp_q.push_back(wv[4]);
        exp_q.push_back(8'h00);
        exp_q.push_back(8'h00);
        exp_q.push_back(wv[6]);
        exp_q.push_back(8'h00);
        exp_q.push_back(ID0);
        host.rd(8'h1b, 2);
        host.rd(8'h3f, 2);
        host.rd(8'hff, 2);
        host.wr(7'h69, 8'h04, 8'h00, ok);
        check({7'h00, ok}, 8'h00);
        lockout = 1'b1;
        host.tick(10);
        exp_q.push_back(8'h00);
        host.rd(8'h00, 1);
        lockout = 1'b0;
        host.tick(10);
        exp_q.push_back(ID0);
        host.rd(8'h00, 1);
        for (int i = 0; i < 1000 && exp_q.size() != 0; i++)
            @(posedge i_clk_sys);
        if (exp_q.size() != 0)
            fails++;
        print_verdict();
    end
endmodule : pmic_identification_registers_tb

// ### test/pmicid_host.sv
// behavioural serial host that drives the register bank's target port
`timescale 1ns/10ps
module pmicid_host #(
    parameter logic [6:0] DEV_ADDR = 7'h68
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_sda,
    output logic            o_scl,
    output logic            o_sda_oe,
    output logic            o_rd_valid,
    output logic [7:0]      o_rd_byte
);
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
        o_rd_valid = 1'b0;
        o_rd_byte = 8'h00;
    end

    // all moves land just after an edge, phases of ten cycles
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : tick

    task automatic start_c;
        tick(10);
        o_sda_oe = 1'b1;
        tick(10);
        o_scl = 1'b0;
    endtask : start_c

    task automatic stop_c;
        tick(2);
        o_sda_oe = 1'b1;
        tick(8);
        o_scl = 1'b1;
        tick(10);
        o_sda_oe = 1'b0;
        tick(10);
    endtask : stop_c

    // a one releases the line so the same cell also reads
    task automatic bit_c(input logic b, output logic s);
        tick(2);
        o_sda_oe = ~b;
        tick(8);
        o_scl = 1'b1;
        tick(5);
        s = i_sda;
        tick(5);
        o_scl = 1'b0;
    endtask : bit_c

    task automatic byte_c(input logic [7:0] b, input logic last,
                          output logic [7:0] s, output logic ack);
        logic n;
        for (int i = 7; i >= 0; i--)
            bit_c(b[i], s[i]);
        bit_c(last, n);
        ack = ~n;
    endtask : byte_c

    task automatic wr(input logic [6:0] dev, input logic [7:0] a,
                      input logic [7:0] d, output logic ok);
        logic [7:0] s;
        logic       k0, k1, k2;
        start_c;
        byte_c({dev, 1'b0}, 1'b1, s, k0);
        byte_c(a, 1'b1, s, k1);
        byte_c(d, 1'b1, s, k2);
        stop_c;
        ok = k0 & k1 & k2;
    endtask : wr

    // burst read, host acks all but last
    task automatic rd(input logic [7:0] a, input int n);
        logic [7:0] s;
        logic       k;
        start_c;
        byte_c({DEV_ADDR, 1'b0}, 1'b1, s, k);
        byte_c(a, 1'b1, s, k);
        stop_c;
        start_c;
        byte_c({DEV_ADDR, 1'b1}, 1'b1, s, k);
        for (int i = 0; i < n; i++) begin
            byte_c(8'hff, (i == n - 1), s, k);
            o_rd_byte = s;
            o_rd_valid = 1'b1;
            tick(1);
            o_rd_valid = 1'b0;
        end
        stop_c;
    endtask : rd
endmodule : pmicid_host
